// *** flash_status_host.sv ***
// Host controller that issues status commands to an asynchronous NOR flash,
// polls its toggle and flag bits, and recovers from timeout and buffer abort.
// Assumes an APB master for software access and flash inputs synchronous to mclk_in.
//
// Register access over APB and the register addresses were left to the implementer.
module flash_status_host #(
    parameter int AW = 26
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic [AW-1:0] flash_addr_out,
    input wire logic [15:0] flash_dq_in,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe_out,
    output logic flash_ce_n_out,
    output logic flash_oe_n_out,
    output logic flash_we_n_out,
    input wire logic ready_busy_in
);

    typedef enum logic [2:0] {M_IDLE, M_WSEQ, M_WWAIT, M_RD, M_RWAIT, M_RECOVER} main_st_type;

    typedef struct packed {
        main_st_type st;
        flash_host_pkg::op_type op;
        logic [1:0] step;
        logic [15:0] cnt;
        logic [AW-1:0] poll_addr;
        logic [7:0] prev;
        logic have_prev;
        logic tlim_seen;
        logic busy;
        logic done;
        logic err_timeout;
        logic err_abort;
        logic tog2;
        logic rdy;
        logic [15:0] data;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic cyc_start;
        logic cyc_write;
        logic [AW-1:0] cyc_addr;
        logic [15:0] cyc_wdata;
    } host_state_type;

    host_state_type s_r;
    host_state_type s_nxt;
    logic cyc_done;
    logic [15:0] cyc_rdata;
    logic [7:0] stat_w;
    logic [7:0] diff_w;

    // ------------------------------------------------------------------
    // Command sequence tables
    // ------------------------------------------------------------------
    function automatic logic [1:0] seq_last(input flash_host_pkg::op_type op);
        seq_last = (op == flash_host_pkg::OP_ABORT_RESET) ? 2'd2 : 2'd0;
    endfunction

    function automatic logic [27:0] seq_word(input flash_host_pkg::op_type op,
                                             input logic [1:0] step);
        seq_word = {12'h000, flash_host_pkg::CMD_RESET};
        unique case (op)
            flash_host_pkg::OP_SR_READ:
                seq_word = {flash_host_pkg::UNLOCK_A1, flash_host_pkg::CMD_SR_READ};
            flash_host_pkg::OP_CLEAR:
                seq_word = {flash_host_pkg::UNLOCK_A1, flash_host_pkg::CMD_SR_CLEAR};
            flash_host_pkg::OP_ABORT_RESET:
                unique case (step)
                    2'd0: seq_word = {flash_host_pkg::UNLOCK_A1, flash_host_pkg::UNLOCK_D1};
                    2'd1: seq_word = {flash_host_pkg::UNLOCK_A2, flash_host_pkg::UNLOCK_D2};
                    default: seq_word = {flash_host_pkg::UNLOCK_A1, flash_host_pkg::CMD_RESET};
                endcase
            default:
                seq_word = {12'h000, flash_host_pkg::CMD_RESET};
        endcase
    endfunction

    // Reserved polling bits are masked before any comparison.
    assign stat_w = cyc_rdata[7:0] & flash_host_pkg::POLL_MASK;
    assign diff_w = stat_w ^ s_r.prev;

    // ------------------------------------------------------------------
    // Register access and sequencing
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [27:0] sw;
        sw = seq_word(s_r.op, s_r.step);
        s_nxt = s_r;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        s_nxt.cyc_start = 1'b0;
        s_nxt.rdy = ready_busy_in;
        if (psel_in && penable_in && !s_r.pready)
        begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h0000_0000;
            unique case (paddr_in)
                flash_host_pkg::REG_CTRL:
                begin
                    s_nxt.prdata[2:0] = s_r.op;
                    // A new order is refused while one runs, so only accepted
                    // commands ever reach a flash in an error state.
                    if (pwrite_in && !s_r.busy && pwdata_in[2:0] >= 3'd1 && pwdata_in[2:0] <= 3'd5)
                    begin
                        s_nxt.op = flash_host_pkg::op_type'(pwdata_in[2:0]);
                        s_nxt.busy = 1'b1;
                        s_nxt.done = 1'b0;
                        s_nxt.err_timeout = 1'b0;
                        s_nxt.err_abort = 1'b0;
                        s_nxt.have_prev = 1'b0;
                        s_nxt.tlim_seen = 1'b0;
                        s_nxt.step = 2'd0;
                        s_nxt.st = (pwdata_in[2:0] == 3'd1) ? M_RD : M_WSEQ;
                    end
                end
                flash_host_pkg::REG_ADDR:
                begin
                    s_nxt.prdata[AW-1:0] = s_r.poll_addr;
                    if (pwrite_in && !s_r.busy)
                    begin
                        s_nxt.poll_addr = pwdata_in[AW-1:0];
                    end
                end
                flash_host_pkg::REG_STAT:
                begin
                    s_nxt.prdata[flash_host_pkg::STAT_BUSY] = s_r.busy;
                    s_nxt.prdata[flash_host_pkg::STAT_DONE] = s_r.done;
                    s_nxt.prdata[flash_host_pkg::STAT_TIMEOUT] = s_r.err_timeout;
                    s_nxt.prdata[flash_host_pkg::STAT_ABORT] = s_r.err_abort;
                    s_nxt.prdata[flash_host_pkg::STAT_TOG2] = s_r.tog2;
                    s_nxt.prdata[flash_host_pkg::STAT_RDY] = s_r.rdy;
                    s_nxt.prdata[flash_host_pkg::STAT_OP +: 3] = s_r.op;
                    if (pwrite_in)
                    begin
                        s_nxt.done = 1'b0;
                    end
                end
                flash_host_pkg::REG_DATA:
                    s_nxt.prdata[15:0] = s_r.data;
                default:
                    s_nxt.pslverr = 1'b1;
            endcase
        end
        // The sequencer runs after the bus decode, so a completion in the
        // same cycle as a software clear of done still sets done.
        unique case (s_r.st)
            M_IDLE:
            begin
            end
            M_WSEQ:
            begin
                s_nxt.cyc_start = 1'b1;
                s_nxt.cyc_write = 1'b1;
                s_nxt.cyc_addr = AW'(sw[27:16]);
                s_nxt.cyc_wdata = sw[15:0];
                s_nxt.st = M_WWAIT;
            end
            M_WWAIT:
            begin
                if (cyc_done)
                begin
                    if (s_r.step != seq_last(s_r.op))
                    begin
                        s_nxt.step = s_r.step + 2'd1;
                        s_nxt.st = M_WSEQ;
                    end
                    else if (s_r.op == flash_host_pkg::OP_SR_READ)
                    begin
                        s_nxt.st = M_RD;
                    end
                    else if (s_r.op == flash_host_pkg::OP_CLEAR)
                    begin
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                        s_nxt.st = M_IDLE;
                    end
                    else
                    begin
                        s_nxt.cnt = 16'(flash_host_pkg::RECOVER_CYC);
                        s_nxt.st = M_RECOVER;
                    end
                end
            end
            M_RD:
            begin
                // Polling always uses the software-given valid address.
                // Keeping a suspended program line out of ADDR is left to software.
                s_nxt.cyc_start = 1'b1;
                s_nxt.cyc_write = 1'b0;
                s_nxt.cyc_addr = s_r.poll_addr;
                s_nxt.st = M_RWAIT;
            end
            M_RWAIT:
            begin
                if (cyc_done)
                begin
                    s_nxt.prev = stat_w;
                    s_nxt.have_prev = 1'b1;
                    s_nxt.st = M_RD;
                    if (s_r.op == flash_host_pkg::OP_SR_READ || (s_r.have_prev
                        && !diff_w[flash_host_pkg::FIRST_TOGGLE_BIT]))
                    begin
                        s_nxt.data = cyc_rdata;
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                        s_nxt.st = M_IDLE;
                    end
                    else if (s_r.have_prev)
                    begin
                        s_nxt.tog2 = diff_w[flash_host_pkg::SECOND_TOGGLE_BIT];
                        if (s_r.tlim_seen)
                        begin
                            s_nxt.err_timeout = 1'b1;
                            s_nxt.op = flash_host_pkg::OP_RESET;
                            s_nxt.step = 2'd0;
                            s_nxt.st = M_WSEQ;
                        end
                        else if (stat_w[flash_host_pkg::TIMING_LIMIT_FLAG])
                        begin
                            // Recheck once, toggling may stop as the flag rises.
                            s_nxt.tlim_seen = 1'b1;
                        end
                        else if (stat_w[flash_host_pkg::BUFFER_ABORT_FLAG])
                        begin
                            s_nxt.err_abort = 1'b1;
                            s_nxt.op = flash_host_pkg::OP_ABORT_RESET;
                            s_nxt.step = 2'd0;
                            s_nxt.st = M_WSEQ;
                        end
                    end
                end
            end
            M_RECOVER:
            begin
                // Busy is tolerated for the whole window, not treated as error.
                s_nxt.cnt = s_r.cnt - 16'h0001;
                if (s_r.cnt == 16'h0000 || ready_busy_in)
                begin
                    s_nxt.busy = 1'b0;
                    s_nxt.done = 1'b1;
                    s_nxt.st = M_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign prdata_out = s_r.prdata;
    assign pready_out = s_r.pready;
    assign pslverr_out = s_r.pslverr;

    flash_bus_cycle #(
        .AW(AW)
    ) u_cycle (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .start_in(s_r.cyc_start),
        .write_in(s_r.cyc_write),
        .addr_in(s_r.cyc_addr),
        .wdata_in(s_r.cyc_wdata),
        .dq_in(flash_dq_in),
        .addr_out(flash_addr_out),
        .dq_out(flash_dq_out),
        .dq_oe_out(flash_dq_oe_out),
        .ce_n_out(flash_ce_n_out),
        .oe_n_out(flash_oe_n_out),
        .we_n_out(flash_we_n_out),
        .rdata_out(cyc_rdata),
        .done_out(cyc_done)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_timeout_then_reset: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_r.st == M_RWAIT && cyc_done && s_r.op == flash_host_pkg::OP_POLL && s_r.have_prev
        && s_r.tlim_seen && diff_w[6] |=> s_r.st == M_WSEQ
        && s_r.op == flash_host_pkg::OP_RESET && s_r.err_timeout)
        else $error("timeout not followed by reset command");
    a_reset_recover_start: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_r.st == M_WWAIT && cyc_done && s_r.op == flash_host_pkg::OP_RESET
        |=> s_r.st == M_RECOVER && s_r.cnt == 16'd200)
        else $error("reset did not open a busy window");
    a_recover_bound: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_r.st == M_RECOVER && s_r.cnt == 16'h0000 |=> s_r.st == M_IDLE && s_r.done)
        else $error("busy window overran");
    a_abort_then_seq: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_r.st == M_RWAIT && cyc_done && s_r.op == flash_host_pkg::OP_POLL && s_r.have_prev
        && !s_r.tlim_seen && diff_w[6] && !stat_w[5] && stat_w[1]
        |=> s_r.op == flash_host_pkg::OP_ABORT_RESET ##1 s_r.cyc_start && s_r.cyc_write)
        else $error("abort not followed by abort reset");
    a_poll_addr_valid: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_r.cyc_start && !s_r.cyc_write && s_r.op == flash_host_pkg::OP_POLL
        |-> s_r.cyc_addr == s_r.poll_addr ##1 flash_addr_out == s_r.poll_addr)
        else $error("status read at wrong address");
    a_reserved_masked: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_r.have_prev |-> s_r.prev[4] == 1'b0 && s_r.prev[0] == 1'b0)
        else $error("reserved polling bits not masked");
    a_busy_holds_order: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_r.busy && s_r.st != M_IDLE |=> $stable(s_r.poll_addr))
        else $error("order changed while busy");
    a_prot_keep_polling: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_r.st == M_RWAIT && cyc_done && s_r.op == flash_host_pkg::OP_POLL && s_r.have_prev
        && !s_r.tlim_seen && diff_w[6] && !stat_w[5] && !stat_w[1]
        |=> s_r.st == M_RD ##1 s_r.cyc_start && !s_r.cyc_write)
        else $error("host wrote during protection busy");

endmodule

// *** flash_host_pkg.sv ***
// Constants shared by the flash status host controller and its bus cycle engine.
// Assumes a 100 MHz single clock and an x16 asynchronous flash on the far side.
package flash_host_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int STROBE_NS = 70;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVER_NS = 2000;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------------
    // Register map, APB byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0C;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_TIMEOUT = 2;
    localparam int STAT_ABORT = 3;
    localparam int STAT_TOG2 = 4;
    localparam int STAT_RDY = 5;
    localparam int STAT_OP = 8;

    // ------------------------------------------------------------------
    // Polling bit positions and reserved-bit mask
    // ------------------------------------------------------------------
    localparam int DATA_POLLING_BIT = 7;
    localparam int FIRST_TOGGLE_BIT = 6;
    localparam int TIMING_LIMIT_FLAG = 5;
    localparam int SECOND_TOGGLE_BIT = 2;
    localparam int BUFFER_ABORT_FLAG = 1;
    localparam logic [7:0] POLL_MASK = 8'hEE;

    // ------------------------------------------------------------------
    // Command words and unlock addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] UNLOCK_A1 = 12'h0555;
    localparam logic [11:0] UNLOCK_A2 = 12'h02AA;
    localparam logic [15:0] UNLOCK_D1 = 16'h00AA;
    localparam logic [15:0] UNLOCK_D2 = 16'h0055;
    localparam logic [15:0] CMD_RESET = 16'h00F0;
    localparam logic [15:0] CMD_SR_READ = 16'h0070;
    localparam logic [15:0] CMD_SR_CLEAR = 16'h0071;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_POLL,
        OP_SR_READ,
        OP_RESET,
        OP_CLEAR,
        OP_ABORT_RESET
    } op_type;

endpackage

// *** flash_bus_cycle.sv ***
// One asynchronous flash read or write cycle with a fixed strobe width.
// Assumes the flash data inputs are synchronous to mclk_in.
module flash_bus_cycle #(
    parameter int AW = 26
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic write_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic [15:0] dq_in,
    output logic [AW-1:0] addr_out,
    output logic [15:0] dq_out,
    output logic dq_oe_out,
    output logic ce_n_out,
    output logic oe_n_out,
    output logic we_n_out,
    output logic [15:0] rdata_out,
    output logic done_out
);

    typedef enum logic [1:0] {C_IDLE, C_STROBE, C_GAP} cyc_st_type;

    typedef struct packed {
        cyc_st_type st;
        logic [7:0] cnt;
        logic [AW-1:0] addr;
        logic [15:0] dq;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [15:0] rdata;
        logic done;
    } cyc_state_type;

    cyc_state_type c_r;
    cyc_state_type c_nxt;

    // ------------------------------------------------------------------
    // Cycle sequencing
    // ------------------------------------------------------------------
    // Data stays driven one cycle past the write strobe to give hold time.
    always_comb
    begin
        c_nxt = c_r;
        c_nxt.done = 1'b0;
        unique case (c_r.st)
            C_IDLE:
            begin
                if (start_in)
                begin
                    c_nxt.addr = addr_in;
                    c_nxt.dq = wdata_in;
                    c_nxt.dq_oe = write_in;
                    c_nxt.ce_n = 1'b0;
                    c_nxt.oe_n = write_in;
                    c_nxt.we_n = ~write_in;
                    c_nxt.cnt = 8'(flash_host_pkg::STROBE_CYC - 1);
                    c_nxt.st = C_STROBE;
                end
            end
            C_STROBE:
            begin
                if (c_r.cnt == 8'h00)
                begin
                    if (c_r.we_n)
                    begin
                        c_nxt.rdata = dq_in;
                    end
                    c_nxt.ce_n = 1'b1;
                    c_nxt.oe_n = 1'b1;
                    c_nxt.we_n = 1'b1;
                    c_nxt.st = C_GAP;
                end
                else
                begin
                    c_nxt.cnt = c_r.cnt - 8'h01;
                end
            end
            C_GAP:
            begin
                c_nxt.dq_oe = 1'b0;
                c_nxt.done = 1'b1;
                c_nxt.st = C_IDLE;
            end
            default:
            begin
                c_nxt.st = C_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            c_r <= '{st: C_IDLE, cnt: 8'h00, addr: '0, dq: 16'h0000, dq_oe: 1'b0,
                     ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rdata: 16'h0000, done: 1'b0};
        end
        else
        begin
            c_r <= c_nxt;
        end
    end

    assign addr_out = c_r.addr;
    assign dq_out = c_r.dq;
    assign dq_oe_out = c_r.dq_oe;
    assign ce_n_out = c_r.ce_n;
    assign oe_n_out = c_r.oe_n;
    assign we_n_out = c_r.we_n;
    assign rdata_out = c_r.rdata;
    assign done_out = c_r.done;

endmodule

// *** flash_status_model.sv ***
// Behavioural flash that answers status polls and the error-clearing commands.
// Assumes host strobes change just after mclk_in edges and bus is resolved outside.
module flash_status_model (
    input wire logic mclk_in,
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic [15:0] dq_in,
    input wire logic [1:0] fault_in,
    input wire logic fault_stb_in,
    output logic [15:0] dq_out,
    output logic ready_busy_out,
    output logic [1:0] mode_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] mode_r = 2'd0;
    logic [11:0] hold_r = 12'd0;
    logic [7:0] sr_r = 8'h80;
    logic [1:0] unl_r = 2'd0;
    logic tog_r = 1'b0;
    logic srd_r = 1'b0;
    logic oe_q = 1'b1;
    logic we_q = 1'b1;
    logic err;
    logic [15:0] q;
    assign err = (mode_r == 2'd1) || (mode_r == 2'd2);
    // Polling overlay on every address while mode_r is nonzero and no status read is pending.
    // Protection busy shows the erasing-sector pattern; the last loaded word has bit 7 set.
    assign q = srd_r ? {8'h00, sr_r} : (mode_r == 2'd0) ? 16'h12A5 : {8'h00, 1'b0, tog_r,
        mode_r == 2'd1, 1'b0, 1'b1, tog_r & (mode_r != 2'd2), mode_r == 2'd2, 1'b0};
    // A deselected bus shows the inverse so a stale value cannot pass for data.
    assign dq_out = (ce_n_in | oe_n_in) ? ~q : q;
    assign ready_busy_out = (mode_r == 2'd0) && (hold_r == 12'd0);
    assign mode_out = mode_r;
    always_ff @(posedge mclk_in)
    begin
        oe_q <= oe_n_in;
        we_q <= we_n_in;
        if (hold_r != 12'd0)
            hold_r <= hold_r - 12'd1;
        if (mode_r == 2'd3 && hold_r == 12'd1)
        begin
            mode_r <= 2'd0;
            sr_r <= 8'h92;
        end
        if (!oe_q && oe_n_in)
        begin
            tog_r <= tog_r ^ (mode_r != 2'd0);
            srd_r <= 1'b0;
        end
        if (fault_stb_in)
        begin
            mode_r <= fault_in;
            hold_r <= 12'd2000;
            sr_r <= (fault_in == 2'd3) ? 8'h00 : (fault_in == 2'd2) ? 8'h98 : 8'h90;
        end
        else if (!we_q && we_n_in)
        begin
            unl_r <= (dq_in[7:0] == 8'hAA) ? 2'd1 : (dq_in[7:0] == 8'h55 && unl_r == 2'd1) ? 2'd2 : 2'd0;
            if (dq_in[7:0] == 8'h70)
                srd_r <= 1'b1;
            if (err && (dq_in[7:0] == 8'h71 || (dq_in[7:0] == 8'hF0
                && (mode_r == 2'd1 || unl_r == 2'd2))))
            begin
                mode_r <= 2'd0;
                sr_r <= 8'h80;
                hold_r <= 12'd100;
            end
        end
    end
endmodule

// *** test_flash_status_host.sv ***
// Bench that drives the host over APB and checks its recovery against the flash model.
// Assumes the model above stands on the flash pins.
module test_flash_status_host;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic fstb = 1'b0;
    logic [1:0] fm = 2'd0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0000_0000;
    logic [31:0] prd, rv;
    logic rdy, err, ev, oe, ce_n, oe_n, we_n, rb;
    logic [15:0] hout, fout, bus;
    logic [25:0] fa;
    logic [1:0] mode;
    int miscompares = 0;
    int comparisons = 0;
    assign bus = oe ? hout : fout;
    always #5 mclk_in = ~mclk_in;
    flash_status_host dut (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(rdy), .pslverr_out(err), .flash_addr_out(fa),
        .flash_dq_in(bus), .flash_dq_out(hout), .flash_dq_oe_out(oe),
        .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n), .flash_we_n_out(we_n),
        .ready_busy_in(rb));
    flash_status_model fmod (.mclk_in(mclk_in), .ce_n_in(ce_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .dq_in(bus), .fault_in(fm), .fault_stb_in(fstb),
        .dq_out(fout), .ready_busy_out(rb), .mode_out(mode));
    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge mclk_in);
        pen <= 1'b1;
        do
            @(posedge mclk_in);
        while (rdy !== 1'b1);
        rv = prd;
        ev = err;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic op(input logic [2:0] c);
        apb(1'b1, flash_host_pkg::REG_CTRL, {29'h0, c});
        do
            apb(1'b0, flash_host_pkg::REG_STAT, 32'h0);
        while (rv[flash_host_pkg::STAT_BUSY] !== 1'b0);
    endtask
    task automatic inject(input logic [1:0] f);
        fm <= f;
        fstb <= 1'b1;
        @(posedge mclk_in);
        fstb <= 1'b0;
    endtask
    initial
    begin
        #200_000;
        miscompares++;
        end_sim();
    end
    initial
    begin
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        apb(1'b0, flash_host_pkg::REG_STAT, 32'h0);
        chk("stat", 32'h0, rv & 32'hF);
        apb(1'b0, 8'h10, 32'h0);
        chk("slverr", 32'h1, {31'h0, ev});
        apb(1'b1, flash_host_pkg::REG_ADDR, 32'h0000_0123);
        op(flash_host_pkg::OP_POLL);
        chk("stat", 32'h2, rv & 32'hF);
        apb(1'b0, flash_host_pkg::REG_DATA, 32'h0);
        chk("data", 32'h0000_12A5, rv);
        for (int f = 1; f < 3; f++)
        begin
            inject(f[1:0]);
            op(flash_host_pkg::OP_POLL);
            chk("stat", (f == 1) ? 32'h16 : 32'hA, rv & 32'h1F);
            chk("mode", 32'h0, {30'h0, mode});
            inject(f[1:0]);
            op(flash_host_pkg::OP_SR_READ);
            apb(1'b0, flash_host_pkg::REG_DATA, 32'h0);
            chk("word", (f == 1) ? 32'h90 : 32'h98, rv);
            op((f == 1) ? flash_host_pkg::OP_RESET : flash_host_pkg::OP_ABORT_RESET);
            chk("mode", 32'h0, {30'h0, mode});
        end
        inject(2'd1);
        op(flash_host_pkg::OP_CLEAR);
        chk("mode", 32'h0, {30'h0, mode});
        inject(2'd3);
        apb(1'b1, flash_host_pkg::REG_CTRL, {29'h0, flash_host_pkg::OP_POLL});
        apb(1'b1, flash_host_pkg::REG_CTRL, {29'h0, flash_host_pkg::OP_SR_READ});
        apb(1'b1, flash_host_pkg::REG_ADDR, 32'h0000_0456);
        apb(1'b0, flash_host_pkg::REG_STAT, 32'h0);
        chk("op", 32'h101, rv & 32'h701);
        op(flash_host_pkg::OP_POLL);
        chk("stat", 32'h22, rv & 32'h2F);
        apb(1'b0, flash_host_pkg::REG_ADDR, 32'h0);
        chk("addr", 32'h0000_0123, rv);
        op(flash_host_pkg::OP_SR_READ);
        apb(1'b0, flash_host_pkg::REG_DATA, 32'h0);
        chk("word", 32'h92, rv);
        end_sim();
    end
endmodule
